// ==== design/core_flags_defines.svh ====
// offsets, field positions and timing counts for the status-flag datapath
`ifndef CORE_FLAGS_DEFINES_SVH
`define CORE_FLAGS_DEFINES_SVH
`define OFS_STATUS_WORD   8'hD0
`define OFS_MAIN_OPERAND  8'hE0
`define OFS_SECOND_OPND   8'hF0
`define BIT_CARRY         7
`define BIT_HALF_CARRY    6
`define BIT_USER_A        5
`define BIT_BANK_HI       4
`define BIT_BANK_LO       3
`define BIT_SIGNED_WRAP   2
`define BIT_USER_B        1
`define BIT_PARITY        0
`define RST_BYTE          8'h00
`define CLKS_PER_MCYCLE   3'h4
`define MCYC_CNT_LAST     2'h3
`define BANK_STRIDE_SHIFT 3
`endif

// ==== design/core_flags_pkg.sv ====
// types for the status-flag datapath
package core_flags_pkg;
  typedef enum logic [4:0] {
    OP_NONE, OP_ADD, OP_ADDC, OP_SUBB, OP_MUL, OP_DIV, OP_DA, OP_RRC, OP_RLC,
    OP_SETB_C, OP_CLR_C, OP_CPL_C, OP_ANL_C, OP_ANL_NC, OP_ORL_C, OP_ORL_NC,
    OP_MOV_C, OP_CJNE, OP_LOAD_A, OP_RR, OP_RL
  } alu_op_t;
  typedef enum logic [1:0] {
    INS_PLAIN, INS_BRANCH
  } ins_kind_t;
  typedef enum {
    ST_IDLE, ST_FETCH, ST_ADDR
  } seq_state_t;
endpackage

// ==== design/core_status_flags_datapath.sv ====
// status word, accumulators, flag update and machine-cycle sequencer
// Function
// - carry set from ALU; bit accumulator
// - half carry from low nibble carry
// - two user flags, software only
// - bank bits map R0-R7 to 00-1Fh
// - overflow: carry into bit7 xor out
// - parity always tracks accumulator ones
// - classic flag effects per instruction
// - machine cycle is four core clocks
// - one code fetch per machine cycle
// - jumps and calls add address cycle
// - add/addc/subb set C,OV,AC; mul/div clear C
// - carry-only ops; setb 1, clr 0
// - eight-bit accumulator and second accumulator
//
// Decided for this implementation: strobed register access.
`include "core_flags_defines.svh"
module core_status_flags_datapath (
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   arst_n,
  // register port
  input  wire logic [7:0]             reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [7:0]             reg_rdata,
  // operation issue
  input  wire logic                   op_valid,
  input  wire core_flags_pkg::alu_op_t op_code,
  input  wire logic [7:0]             op_operand,
  input  wire logic                   op_bit,
  // instruction sequencing
  input  wire logic                   ins_start,
  input  wire core_flags_pkg::ins_kind_t ins_kind,
  input  wire logic [1:0]             ins_bytes,
  output logic                        ins_busy,
  output logic                        fetch_strobe,
  output logic                        addr_calc_strobe,
  output logic                        mcycle_start,
  // status outputs
  output logic [7:0]                  main_operand,
  output logic [7:0]                  second_operand,
  output logic [7:0]                  status_word,
  output logic [4:0]                  bank_base_addr
);
  import core_flags_pkg::*;

  logic       rst_sync1_r;
  logic       rst_sync2_r;
  logic       rst_n;
  logic [7:0] acc_r;
  logic [7:0] acc_nxt;
  logic [7:0] b_r;
  logic [7:0] b_nxt;
  logic       cy_r;
  logic       cy_nxt;
  logic       ac_r;
  logic       ac_nxt;
  logic       ov_r;
  logic       ov_nxt;
  logic       f0_r;
  logic       f1_r;
  logic [1:0] bank_r;
  logic       parity;
  logic [7:0] rdata_r;
  logic [1:0] phase_r;
  logic [1:0] fetch_left_r;
  logic       branch_r;
  seq_state_t state_r;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync1_r <= 1'b0;
      rst_sync2_r <= 1'b0;
    end else begin
      rst_sync1_r <= 1'b1;
      rst_sync2_r <= rst_sync1_r;
    end
  end
  assign rst_n = rst_sync2_r;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // arithmetic and flag next-state
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] sum7;
  logic [15:0] prod;
  logic [8:0] da_tmp;
  logic       cin;
  always_comb begin
    acc_nxt = acc_r;
    b_nxt   = b_r;
    cy_nxt  = cy_r;
    ac_nxt  = ac_r;
    ov_nxt  = ov_r;
    sum9    = 9'h000;
    sum5    = 5'h00;
    sum7    = 8'h00;
    prod    = 16'h0000;
    da_tmp  = 9'h000;
    cin     = (op_code == OP_ADDC || op_code == OP_SUBB) ? cy_r : 1'b0;
    if (op_valid) begin
      case (op_code)
        OP_ADD, OP_ADDC: begin
          sum9 = {1'b0, acc_r} + {1'b0, op_operand} + {8'h00, cin};
          sum5 = {1'b0, acc_r[3:0]} + {1'b0, op_operand[3:0]} + {4'h0, cin};
          sum7 = {1'b0, acc_r[6:0]} + {1'b0, op_operand[6:0]} + {7'h00, cin};
          acc_nxt = sum9[7:0];
          cy_nxt  = sum9[8];
          ac_nxt  = sum5[4];
          ov_nxt  = sum9[8] ^ sum7[7];
        end
        OP_SUBB: begin
          sum9 = {1'b0, acc_r} - {1'b0, op_operand} - {8'h00, cin};
          sum5 = {1'b0, acc_r[3:0]} - {1'b0, op_operand[3:0]} - {4'h0, cin};
          sum7 = {1'b0, acc_r[6:0]} - {1'b0, op_operand[6:0]} - {7'h00, cin};
          acc_nxt = sum9[7:0];
          cy_nxt  = sum9[8];
          ac_nxt  = sum5[4];
          ov_nxt  = sum9[8] ^ sum7[7];
        end
        OP_MUL: begin
          prod    = acc_r * b_r;
          acc_nxt = prod[7:0];
          b_nxt   = prod[15:8];
          cy_nxt  = 1'b0;
          ov_nxt  = (prod[15:8] != 8'h00);
        end
        OP_DIV: begin
          cy_nxt = 1'b0;
          if (b_r == 8'h00) begin
            ov_nxt = 1'b1;
          end else begin
            acc_nxt = acc_r / b_r;
            b_nxt   = acc_r % b_r;
            ov_nxt  = 1'b0;
          end
        end
        OP_DA: begin
          da_tmp = {1'b0, acc_r};
          if (acc_r[3:0] > 4'h9 || ac_r) begin
            da_tmp = da_tmp + 9'h006;
          end
          if (da_tmp[7:4] > 4'h9 || cy_r || da_tmp[8]) begin
            da_tmp = da_tmp + 9'h060;
          end
          acc_nxt = da_tmp[7:0];
          cy_nxt  = cy_r | da_tmp[8];
        end
        OP_RRC: begin
          acc_nxt = {cy_r, acc_r[7:1]};
          cy_nxt  = acc_r[0];
        end
        OP_RLC: begin
          acc_nxt = {acc_r[6:0], cy_r};
          cy_nxt  = acc_r[7];
        end
        OP_RR: begin
          acc_nxt = {acc_r[0], acc_r[7:1]};
        end
        OP_RL: begin
          acc_nxt = {acc_r[6:0], acc_r[7]};
        end
        OP_LOAD_A: begin
          acc_nxt = op_operand;
        end
        OP_SETB_C: begin
          cy_nxt = 1'b1;
        end
        OP_CLR_C: begin
          cy_nxt = 1'b0;
        end
        OP_CPL_C: begin
          cy_nxt = ~cy_r;
        end
        OP_ANL_C: begin
          cy_nxt = cy_r & op_bit;
        end
        OP_ANL_NC: begin
          cy_nxt = cy_r & ~op_bit;
        end
        OP_ORL_C: begin
          cy_nxt = cy_r | op_bit;
        end
        OP_ORL_NC: begin
          cy_nxt = cy_r | ~op_bit;
        end
        OP_MOV_C: begin
          cy_nxt = op_bit;
        end
        OP_CJNE: begin
          cy_nxt = (acc_r < op_operand);
        end
        default: begin
        end
      endcase
    end
  end

  // accumulators: operations win over software writes in the same cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r <= `RST_BYTE;
      b_r   <= `RST_BYTE;
    end else if (op_valid) begin
      acc_r <= acc_nxt;
      b_r   <= b_nxt;
    end else if (reg_wr && hit(reg_addr, `OFS_MAIN_OPERAND)) begin
      acc_r <= reg_wdata;
    end else if (reg_wr && hit(reg_addr, `OFS_SECOND_OPND)) begin
      b_r <= reg_wdata;
    end
  end

  // carry flag: hardware update wins over software write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cy_r <= 1'b0;
    end else if (op_valid) begin
      cy_r <= cy_nxt;
    end else if (reg_wr && hit(reg_addr, `OFS_STATUS_WORD)) begin
      cy_r <= reg_wdata[`BIT_CARRY];
    end
  end

  // half carry flag
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ac_r <= 1'b0;
    end else if (op_valid) begin
      ac_r <= ac_nxt;
    end else if (reg_wr && hit(reg_addr, `OFS_STATUS_WORD)) begin
      ac_r <= reg_wdata[`BIT_HALF_CARRY];
    end
  end

  // signed wrap flag
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ov_r <= 1'b0;
    end else if (op_valid) begin
      ov_r <= ov_nxt;
    end else if (reg_wr && hit(reg_addr, `OFS_STATUS_WORD)) begin
      ov_r <= reg_wdata[`BIT_SIGNED_WRAP];
    end
  end

  // software-only fields
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      f0_r   <= 1'b0;
      f1_r   <= 1'b0;
      bank_r <= 2'h0;
    end else if (reg_wr && hit(reg_addr, `OFS_STATUS_WORD)) begin
      f0_r   <= reg_wdata[`BIT_USER_A];
      f1_r   <= reg_wdata[`BIT_USER_B];
      bank_r <= {reg_wdata[`BIT_BANK_HI], reg_wdata[`BIT_BANK_LO]};
    end
  end

  assign parity = ^acc_r;
  assign bank_base_addr = 5'(bank_r) << `BANK_STRIDE_SHIFT;

  always_comb begin
    status_word = `RST_BYTE;
    status_word[`BIT_CARRY]       = cy_r;
    status_word[`BIT_HALF_CARRY]  = ac_r;
    status_word[`BIT_USER_A]      = f0_r;
    status_word[`BIT_BANK_HI]     = bank_r[1];
    status_word[`BIT_BANK_LO]     = bank_r[0];
    status_word[`BIT_SIGNED_WRAP] = ov_r;
    status_word[`BIT_USER_B]      = f1_r;
    status_word[`BIT_PARITY]      = parity;
  end
  assign main_operand   = acc_r;
  assign second_operand = b_r;

  // register read, data one cycle later
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= `RST_BYTE;
    end else if (reg_rd) begin
      if (hit(reg_addr, `OFS_STATUS_WORD)) begin
        rdata_r <= status_word;
      end else if (hit(reg_addr, `OFS_MAIN_OPERAND)) begin
        rdata_r <= acc_r;
      end else if (hit(reg_addr, `OFS_SECOND_OPND)) begin
        rdata_r <= b_r;
      end else begin
        rdata_r <= `RST_BYTE;
      end
    end else begin
      rdata_r <= `RST_BYTE;
    end
  end
  assign reg_rdata = rdata_r;

  // machine-cycle phase counter
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end
  assign mcycle_start = (phase_r == 2'h0);

  // instruction sequencer: one fetch per machine cycle, extra for branches
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r      <= ST_IDLE;
      fetch_left_r <= 2'h0;
      branch_r     <= 1'b0;
    end else if (phase_r == `MCYC_CNT_LAST) begin
      case (state_r)
        ST_IDLE: begin
          if (ins_start && ins_bytes != 2'h0) begin
            state_r      <= ST_FETCH;
            fetch_left_r <= ins_bytes;
            branch_r     <= (ins_kind == INS_BRANCH);
          end
        end
        ST_FETCH: begin
          if (fetch_left_r == 2'h1) begin
            state_r <= branch_r ? ST_ADDR : ST_IDLE;
          end
          fetch_left_r <= fetch_left_r - 2'h1;
        end
        ST_ADDR: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
  assign ins_busy         = (state_r != ST_IDLE);
  assign fetch_strobe     = (state_r == ST_FETCH) && mcycle_start;
  assign addr_calc_strobe = (state_r == ST_ADDR) && mcycle_start;
endmodule

// ==== tb/core_flags_properties.sv ====
// concurrent checks on the status-flag datapath ports
module core_flags_properties (
  // clock and reset
  input wire logic                    core_clk,
  input wire logic                    arst_n,
  // stimulus seen
  input wire logic [7:0]              reg_addr,
  input wire logic                    reg_wr,
  input wire logic                    op_valid,
  input wire core_flags_pkg::alu_op_t op_code,
  input wire logic [7:0]              op_operand,
  // outputs watched
  input wire logic                    fetch_strobe,
  input wire logic                    addr_calc_strobe,
  input wire logic                    mcycle_start,
  input wire logic [7:0]              main_operand,
  input wire logic [7:0]              status_word,
  input wire logic [4:0]              bank_base_addr
);
  timeunit 1ns;
  timeprecision 100ps;
  import core_flags_pkg::*;
  logic [8:0] sum_r;
  logic [7:0] low7_r;
  logic [4:0] nib_r;
  // expected add results
  always_ff @(posedge core_clk) begin
    sum_r  <= {1'b0, main_operand} + {1'b0, op_operand};
    low7_r <= {1'b0, main_operand[6:0]} + {1'b0, op_operand[6:0]};
    nib_r  <= {1'b0, main_operand[3:0]} + {1'b0, op_operand[3:0]};
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence quiet3;
    !mcycle_start [*3];
  endsequence
  sequence no_fetch3;
    !fetch_strobe [*3];
  endsequence
  a_parity_live: assert property (status_word[0] == ^main_operand)
    else $error("parity wrong");
  a_bank_map: assert property (bank_base_addr == {status_word[4:3], 3'h0})
    else $error("bank base wrong");
  a_mcycle_four: assert property ($rose(mcycle_start) |=> quiet3 ##1 mcycle_start)
    else $error("machine cycle length wrong");
  a_fetch_single: assert property (fetch_strobe |-> mcycle_start ##1 no_fetch3)
    else $error("fetch placement wrong");
  a_addr_after: assert property (addr_calc_strobe |-> $past(fetch_strobe, 4))
    else $error("address cycle not after fetch");
  a_add_flags: assert property (op_valid && op_code == OP_ADD |=>
    status_word[7] == sum_r[8] && status_word[6] == nib_r[4]
    && status_word[2] == (low7_r[7] ^ sum_r[8]))
    else $error("add flags wrong");
  a_muldiv_clr: assert property (op_valid && op_code inside {OP_MUL, OP_DIV}
    |=> !status_word[7])
    else $error("carry not cleared");
  a_setb_one: assert property (op_valid && op_code == OP_SETB_C |=> status_word[7])
    else $error("carry not set");
  a_clr_zero: assert property (op_valid && op_code == OP_CLR_C |=> !status_word[7])
    else $error("carry not cleared");
  a_user_kept: assert property (!(reg_wr && reg_addr == 8'hD0) |=>
    $stable(status_word[5]) && $stable(status_word[1]))
    else $error("user flag changed");
endmodule
bind core_status_flags_datapath core_flags_properties u_core_flags_properties (
  .core_clk, .arst_n, .reg_addr, .reg_wr, .op_valid, .op_code, .op_operand,
  .fetch_strobe, .addr_calc_strobe, .mcycle_start, .main_operand, .status_word,
  .bank_base_addr
);

// ==== tb/tb.sv ====
// register, operation and sequencer tests for the status-flag datapath
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import core_flags_pkg::*;
  logic       core_clk = 1'b0;
  logic       arst_n   = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, op_operand;
  logic [7:0] main_operand, second_operand, status_word;
  logic [4:0] bank_base_addr;
  logic [1:0] ins_bytes;
  logic       reg_wr, reg_rd, op_valid, op_bit, ins_start;
  logic       ins_busy, fetch_strobe, addr_calc_strobe, mcycle_start;
  alu_op_t    op_code;
  ins_kind_t  ins_kind;
  int         n_errors, total_checks, cyc;
  logic [7:0] ra [4] = '{8'hD0, 8'hE0, 8'hF0, 8'hA0};
  alu_op_t    o [15] = '{OP_ADD, OP_ADDC, OP_SUBB, OP_SETB_C, OP_MUL, OP_DIV, OP_CLR_C,
    OP_CPL_C, OP_ANL_C, OP_ORL_C, OP_ANL_NC, OP_ORL_NC, OP_MOV_C, OP_CJNE, OP_RLC};
  logic [7:0] v [15]  = '{0:8'h88, 1:8'h7F, 2:8'h01, 13:8'hFF, default:8'h00};
  logic [14:0] bt     = 15'h0600;
  logic [7:0] ea [15] = '{0:8'h00, 1:8'h80, 2:8'h7F, 3:8'h7F, 14:8'hFD, default:8'hFE};
  logic [7:0] es [15] = '{8'hC0, 8'h45, 8'h45, 8'hC5, 8'h41, 8'h45, 8'h45, 8'hC5,
    8'h45, 8'hC5, 8'h45, 8'hC5, 8'h45, 8'hC5, 8'hC5};
  always #2.5 core_clk = ~core_clk;
  core_status_flags_datapath u_core_status_flags_datapath (
    .core_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .op_valid, .op_code, .op_operand, .op_bit, .ins_start, .ins_kind, .ins_bytes,
    .ins_busy, .fetch_strobe, .addr_calc_strobe, .mcycle_start, .main_operand,
    .second_operand, .status_word, .bank_base_addr
  );
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    @(negedge core_clk);
    chk8(reg_rdata, exp);
  endtask
  task automatic op(input alu_op_t c, input logic [7:0] d, input logic b);
    @(posedge core_clk);
    op_valid   <= 1'b1;
    op_code    <= c;
    op_operand <= d;
    op_bit     <= b;
    @(posedge core_clk);
    op_valid   <= 1'b0;
    @(negedge core_clk);
  endtask
  task automatic ins(input ins_kind_t k, input logic [1:0] n, input int ef, input int ea_n);
    int f = 0;
    int a = 0;
    int b = 0;
    @(posedge core_clk iff mcycle_start);
    ins_start <= 1'b1;
    ins_kind  <= k;
    ins_bytes <= n;
    repeat (3) @(posedge core_clk);
    ins_start <= 1'b0;
    repeat (16) begin
      @(negedge core_clk);
      f += int'(fetch_strobe === 1'b1);
      a += int'(addr_calc_strobe === 1'b1);
      b += int'(ins_busy === 1'b1);
    end
    chk8(8'(f), 8'(ef));
    chk8(8'(a), 8'(ea_n));
    chk8(8'(b), 8'(4 * (ef + ea_n)));
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, op_valid, op_operand, op_bit} = '0;
    {ins_start, ins_bytes} = '0;
    op_code  = OP_NONE;
    ins_kind = INS_PLAIN;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    foreach (ra[i]) rd(ra[i], 8'h00);
    wr(8'hE0, 8'h03);
    wr(8'hD0, 8'hFF);
    rd(8'hD0, 8'hFE);
    for (int b = 0; b < 4; b++) begin
      wr(8'hD0, 8'(b << 3));
      chk8({3'h0, bank_base_addr}, 8'(b * 8));
    end
    wr(8'hD0, 8'h00);
    wr(8'hE0, 8'h78);
    wr(8'hF0, 8'h02);
    for (int i = 0; i < 15; i++) begin
      op(o[i], v[i], bt[i]);
      chk8(main_operand, ea[i]);
      chk8(status_word, es[i]);
    end
    rd(8'hF0, 8'h00);
    chk8(second_operand, 8'h00);
    op(OP_LOAD_A, 8'h15, 1'b0);
    chk8(main_operand, 8'h15);
    chk8(status_word, 8'hC5);
    op(OP_DA, 8'h00, 1'b0);
    chk8(main_operand, 8'h7B);
    chk8(status_word, 8'hC4);
    op(OP_RRC, 8'h00, 1'b0);
    chk8(main_operand, 8'hBD);
    chk8(status_word, 8'hC4);
    op(OP_RR, 8'h00, 1'b0);
    chk8(main_operand, 8'hDE);
    chk8(status_word, 8'hC4);
    op(OP_RL, 8'h00, 1'b0);
    chk8(main_operand, 8'hBD);
    chk8(status_word, 8'hC4);
    ins(INS_BRANCH, 2'h2, 2, 1);
    ins(INS_PLAIN, 2'h3, 3, 0);
    ins(INS_PLAIN, 2'h1, 1, 0);
    give_verdict();
  end
endmodule
